//--- hdl/sqr_port.v
/*
 * Serial command port of a radio transmitter: receives a command byte and
 * parameter bytes from the host, answers the reply read with a handshake
 * byte and, if ready, reply data, and serves four quick-read registers singly or in
 * a wrapping burst without the handshake.
 * Assumes the internal processor supplies the reply buffer, a done level
 * and the quick-read sources on clk_sys_i; the pins are asynchronous.
 */
`timescale 1ns/1ps
`include "sqr_defs.vh"
module sqr_port #(
	parameter N_SRC = 8,
	parameter SEL_W = 3,
	parameter REPLY_BYTES = 16,
	parameter REPLY_IDX_W = 4
) (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire sclk_i,
	input wire select_n_line_i,
	input wire serial_in_line_i,
	output wire serial_out_line_o,
	output wire serial_out_line_oe_o,
	input wire [N_SRC*8-1:0] qr_src_i,
	input wire [4*SEL_W-1:0] quick_read_source_property_i,
	input wire [REPLY_BYTES*8-1:0] reply_buf_i,
	input wire proc_done_i,
	output wire [7:0] cmd_byte_o,
	output wire cmd_strobe_o,
	output wire cmd_first_o,
	output wire cmd_end_o,
	output wire cts_o
);
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_CMD = 3'h1;
	localparam [2:0] ST_QR = 3'h2;
	localparam [2:0] ST_REPLY = 3'h3;
	localparam [2:0] ST_PARAM = 3'h4;
	localparam integer CTS_CYCLES = `SQR_CTS_CYCLES;
	localparam [`SQR_CTS_CNT_W-1:0] CTS_LOAD =
		CTS_CYCLES[`SQR_CTS_CNT_W-1:0];

	function is_qr;
		input [7:0] code;
		begin
			is_qr = (code == `SQR_CMD_QR_A) || (code == `SQR_CMD_QR_B) ||
				(code == `SQR_CMD_QR_C) || (code == `SQR_CMD_QR_D);
		end
	endfunction

	function [1:0] qr_index;
		input [7:0] code;
		begin
			case (code)
			`SQR_CMD_QR_A: qr_index = `SQR_QR_IDX_A;
			`SQR_CMD_QR_B: qr_index = `SQR_QR_IDX_B;
			`SQR_CMD_QR_C: qr_index = `SQR_QR_IDX_C;
			`SQR_CMD_QR_D: qr_index = `SQR_QR_IDX_D;
			default: qr_index = `SQR_QR_IDX_A;
			endcase
		end
	endfunction

	function [7:0] src_pick;
		input [N_SRC*8-1:0] srcs;
		input [SEL_W-1:0] sel;
		begin
			if (sel < N_SRC)
				src_pick = srcs[sel*8 +: 8];
			else
				src_pick = `SQR_FILL_BYTE;
		end
	endfunction

	function [7:0] reply_pick;
		input [REPLY_BYTES*8-1:0] buf_v;
		input [REPLY_IDX_W-1:0] idx;
		begin
			reply_pick = buf_v[idx*8 +: 8];
		end
	endfunction

	wire s_sclk;
	wire s_sel_n;
	wire s_sdi;

	sqr_sync #(
		.W(3),
		.RST_VAL(`SQR_RST_PINS)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.d_i({sclk_i, select_n_line_i, serial_in_line_i}),
		.q_o({s_sclk, s_sel_n, s_sdi})
	);

	reg prev_sclk_ff;
	reg prev_sel_n_ff;
	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg [`SQR_BIT_CNT_W-1:0] bit_cnt_ff;
	reg [`SQR_BIT_CNT_W-1:0] nxt_bit_cnt;
	reg [7:0] rx_ff;
	reg [7:0] nxt_rx;
	reg [7:0] tx_ff;
	reg [7:0] nxt_tx;
	reg sdo_ff;
	reg nxt_sdo;
	reg oe_ff;
	reg nxt_oe;
	reg [1:0] qr_idx_ff;
	reg [1:0] nxt_qr_idx;
	reg [7:0] qr_ff [0:3];
	reg [REPLY_IDX_W-1:0] reply_idx_ff;
	reg [REPLY_IDX_W-1:0] nxt_reply_idx;
	reg reply_ok_ff;
	reg nxt_reply_ok;
	reg cmd_seen_ff;
	reg nxt_cmd_seen;
	reg [7:0] cmd_byte_ff;
	reg [7:0] nxt_cmd_byte;
	reg cmd_strobe_ff;
	reg nxt_cmd_strobe;
	reg cmd_first_ff;
	reg nxt_cmd_first;
	reg cmd_end_ff;
	reg nxt_cmd_end;
	reg cts_ff;
	reg [`SQR_CTS_CNT_W-1:0] cts_cnt_ff;

	// Edges seen on the synchronised pins; the link is oversampled
	// by at least SQR_SCLK_HALF_CYC cycles per half period
	wire sclk_rise = s_sclk & ~prev_sclk_ff;
	wire sclk_fall = ~s_sclk & prev_sclk_ff;
	wire sel_fall = prev_sel_n_ff & ~s_sel_n;
	wire sel_rise = ~prev_sel_n_ff & s_sel_n;
	wire byte_done = sclk_rise && (bit_cnt_ff == `SQR_BIT_LAST);
	wire [7:0] rx_byte = {rx_ff[6:0], s_sdi};

	always @* begin
		nxt_state = state_ff;
		nxt_bit_cnt = bit_cnt_ff;
		nxt_rx = rx_ff;
		nxt_tx = tx_ff;
		nxt_sdo = sdo_ff;
		nxt_oe = oe_ff;
		nxt_qr_idx = qr_idx_ff;
		nxt_reply_idx = reply_idx_ff;
		nxt_reply_ok = reply_ok_ff;
		nxt_cmd_seen = cmd_seen_ff;
		nxt_cmd_byte = cmd_byte_ff;
		nxt_cmd_strobe = 1'b0;
		nxt_cmd_first = cmd_first_ff;
		nxt_cmd_end = 1'b0;
		if (sel_fall) begin
			// A transfer only starts on select falling
			nxt_state = ST_CMD;
			nxt_bit_cnt = {`SQR_BIT_CNT_W{1'b0}};
			nxt_tx = `SQR_FILL_BYTE;
			nxt_sdo = 1'b0;
			nxt_oe = 1'b1;
			nxt_cmd_seen = 1'b0;
		end else if (sel_rise) begin
			nxt_state = ST_IDLE;
			nxt_oe = 1'b0;
			nxt_cmd_end = cmd_seen_ff;
		end else if (!s_sel_n && state_ff != ST_IDLE) begin
			if (sclk_rise) begin
				// Input sampled on rising edges, MSB first
				nxt_rx = rx_byte;
				nxt_bit_cnt = bit_cnt_ff + 1'b1;
			end else if (sclk_fall) begin
				// Output changes on falling edges, MSB first
				nxt_sdo = tx_ff[7];
				nxt_tx = {tx_ff[6:0], 1'b0};
			end
			if (byte_done) begin
				case (state_ff)
				ST_CMD: begin
					// First byte is the command code
					if (is_qr(rx_byte)) begin
						// No handshake before quick-read data
						nxt_state = ST_QR;
						nxt_tx = qr_ff[qr_index(rx_byte)];
						nxt_qr_idx = qr_index(rx_byte) + 2'h1;
					end else if (rx_byte == `SQR_CMD_READ_REPLY) begin
						// Handshake byte precedes reply data
						nxt_state = ST_REPLY;
						nxt_tx = cts_ff ? `SQR_CTS_READY : `SQR_CTS_BUSY;
						nxt_reply_ok = cts_ff;
						nxt_reply_idx = {REPLY_IDX_W{1'b0}};
					end else begin
						nxt_state = ST_PARAM;
						nxt_cmd_byte = rx_byte;
						nxt_cmd_strobe = 1'b1;
						nxt_cmd_first = 1'b1;
						nxt_cmd_seen = 1'b1;
					end
				end
				ST_QR: begin
					// Next register each eight clocks, wrapping D to A
					nxt_tx = qr_ff[qr_idx_ff];
					nxt_qr_idx = qr_idx_ff + 2'h1;
				end
				ST_REPLY: begin
					// Busy handshake leaves only filler; host retries
					if (reply_ok_ff) begin
						nxt_tx = reply_pick(reply_buf_i, reply_idx_ff);
						nxt_reply_idx = reply_idx_ff + 1'b1;
					end else begin
						nxt_tx = `SQR_FILL_BYTE;
					end
				end
				ST_PARAM: begin
					// Parameter bytes pass on one by one
					nxt_cmd_byte = rx_byte;
					nxt_cmd_strobe = 1'b1;
					nxt_cmd_first = 1'b0;
				end
				default: begin
					nxt_state = ST_IDLE;
				end
				endcase
			end
		end
	end

	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			prev_sclk_ff <= 1'b0;
			prev_sel_n_ff <= 1'b1;
			state_ff <= ST_IDLE;
			bit_cnt_ff <= {`SQR_BIT_CNT_W{1'b0}};
			rx_ff <= 8'h00;
			tx_ff <= 8'h00;
			sdo_ff <= 1'b0;
			oe_ff <= 1'b0;
			qr_idx_ff <= 2'h0;
			reply_idx_ff <= {REPLY_IDX_W{1'b0}};
			reply_ok_ff <= 1'b0;
			cmd_seen_ff <= 1'b0;
			cmd_byte_ff <= 8'h00;
			cmd_strobe_ff <= 1'b0;
			cmd_first_ff <= 1'b0;
			cmd_end_ff <= 1'b0;
		end else begin
			prev_sclk_ff <= s_sclk;
			prev_sel_n_ff <= s_sel_n;
			state_ff <= nxt_state;
			bit_cnt_ff <= nxt_bit_cnt;
			rx_ff <= nxt_rx;
			tx_ff <= nxt_tx;
			sdo_ff <= nxt_sdo;
			oe_ff <= nxt_oe;
			qr_idx_ff <= nxt_qr_idx;
			reply_idx_ff <= nxt_reply_idx;
			reply_ok_ff <= nxt_reply_ok;
			cmd_seen_ff <= nxt_cmd_seen;
			cmd_byte_ff <= nxt_cmd_byte;
			cmd_strobe_ff <= nxt_cmd_strobe;
			cmd_first_ff <= nxt_cmd_first;
			cmd_end_ff <= nxt_cmd_end;
		end
	end

	// Snapshot taken only at select falling so a burst sees one
	// coherent set of values
	integer i;
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			for (i = 0; i < 4; i = i + 1)
				qr_ff[i] <= 8'h00;
		end else if (sel_fall) begin
			for (i = 0; i < 4; i = i + 1)
				qr_ff[i] <= src_pick(qr_src_i,
					quick_read_source_property_i[i*SEL_W +: SEL_W]);
		end
	end

	// Handshake: a finished command other than a quick read or reply read clears it; it returns after the
	// typical delay once the processor reports done
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			cts_ff <= `SQR_RST_CTS;
			cts_cnt_ff <= {`SQR_CTS_CNT_W{1'b0}};
		end else if (cmd_end_ff) begin
			cts_ff <= 1'b0;
			cts_cnt_ff <= CTS_LOAD;
		end else if (cts_cnt_ff != {`SQR_CTS_CNT_W{1'b0}}) begin
			cts_cnt_ff <= cts_cnt_ff - 1'b1;
		end else if (proc_done_i) begin
			cts_ff <= 1'b1;
		end
	end

	assign serial_out_line_o = sdo_ff;
	assign serial_out_line_oe_o = oe_ff;
	assign cmd_byte_o = cmd_byte_ff;
	assign cmd_strobe_o = cmd_strobe_ff;
	assign cmd_first_o = cmd_first_ff;
	assign cmd_end_o = cmd_end_ff;
	assign cts_o = cts_ff;
endmodule

//--- include/sqr_defs.vh
/*
 * Constants of the serial command port with quick reads: command codes,
 * handshake values and timing counts.
 * Assumes it is included by bare name from the design files.
 */
`ifndef SQR_DEFS_VH
`define SQR_DEFS_VH

// System clock rate in MHz
`define SQR_CLK_MHZ 100
// Fastest serial clock the port must follow, in MHz
`define SQR_SCLK_MAX_MHZ 10
// Shortest serial clock half period in system cycles, rounded down
`define SQR_SCLK_HALF_CYC ((`SQR_CLK_MHZ / `SQR_SCLK_MAX_MHZ) / 2)

// Bits per byte on the link and its counter width
`define SQR_BYTE_BITS 8
`define SQR_BIT_CNT_W 3
`define SQR_BIT_LAST 3'h7

// Quick-read command codes
`define SQR_CMD_QR_A 8'h50
`define SQR_CMD_QR_B 8'h51
`define SQR_CMD_QR_C 8'h53
`define SQR_CMD_QR_D 8'h57
// Command that returns the handshake byte then the reply
`define SQR_CMD_READ_REPLY 8'h44

// Quick-read register indices
`define SQR_QR_IDX_A 2'h0
`define SQR_QR_IDX_B 2'h1
`define SQR_QR_IDX_C 2'h2
`define SQR_QR_IDX_D 2'h3

// Handshake byte values
`define SQR_CTS_READY 8'hFF
`define SQR_CTS_BUSY 8'h00
// Filler shifted out where no data is defined
`define SQR_FILL_BYTE 8'h00

// Typical handshake delay after a command, in microseconds
`define SQR_CTS_TYP_US 20
`define SQR_CTS_CYCLES (`SQR_CTS_TYP_US * `SQR_CLK_MHZ)
`define SQR_CTS_CNT_W 12

// Reset values
`define SQR_RST_CTS 1'b1
`define SQR_RST_PINS 3'h2

`endif

//--- hdl/sqr_sync.v
/*
 * Two-flop synchroniser for a group of asynchronous pin levels.
 * Assumes each bit is a slow level relative to clk_sys_i.
 */
`timescale 1ns/1ps
module sqr_sync #(
	parameter W = 3,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire [W-1:0] d_i,
	output wire [W-1:0] q_o
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	// First stage feeds only the second stage
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= d_i;
			sync_ff <= meta_ff;
		end
	end

	assign q_o = sync_ff;
endmodule

//--- verif/sqr_port_properties.sv
/* Assertions on the port pins and handshake flags.
 * Bound to sqr_port; sees its ports only. */
`timescale 1ns/1ps
module sqr_port_props (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire sclk_i,
	input wire select_n_line_i,
	input wire serial_out_line_o,
	input wire serial_out_line_oe_o,
	input wire proc_done_i,
	input wire cmd_strobe_o,
	input wire cmd_end_o,
	input wire cts_o
);
	logic [11:0] low_ff;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// Busy length, saturating so it cannot wrap
	always @(posedge clk_sys_i) begin
		if (!rst_n_i || cts_o)
			low_ff <= 12'h000;
		else if (low_ff != 12'hFFF)
			low_ff <= low_ff + 12'h001;
	end
	AST_OE_OFF: assert property (select_n_line_i [*5] |->
		!serial_out_line_oe_o) else $error("out driven while idle");
	AST_OE_ON: assert property (!select_n_line_i [*5] |->
		serial_out_line_oe_o) else $error("out not driven in frame");
	AST_OUT_FALL: assert property ($changed(serial_out_line_o) |->
		!sclk_i) else $error("out moved while clock high");
	AST_OUT_HOLD: assert property ($rose(sclk_i) |->
		$stable(serial_out_line_o) [*4]) else $error("out moved at rise");
	AST_STROBE_PULSE: assert property (cmd_strobe_o |=>
		!cmd_strobe_o) else $error("strobe longer than one cycle");
	AST_END_PULSE: assert property (cmd_end_o |=>
		!cmd_end_o && !cts_o) else $error("end pulse or busy wrong");
	AST_CTS_FALL: assert property ($fell(cts_o) |->
		$past(cmd_end_o)) else $error("busy without command end");
	AST_CTS_WAIT: assert property ($rose(cts_o) |->
		low_ff >= 12'h7CF && $past(proc_done_i))
		else $error("ready too early");
	cover property ($fell(select_n_line_i));
	cover property (cmd_end_o);
	cover property ($rose(cts_o));
endmodule

bind sqr_port sqr_port_props u_props (.clk_sys_i(clk_sys_i),
	.rst_n_i(rst_n_i), .sclk_i(sclk_i),
	.select_n_line_i(select_n_line_i),
	.serial_out_line_o(serial_out_line_o),
	.serial_out_line_oe_o(serial_out_line_oe_o),
	.proc_done_i(proc_done_i), .cmd_strobe_o(cmd_strobe_o),
	.cmd_end_o(cmd_end_o), .cts_o(cts_o));

//--- verif/sqr_host.sv
/* Host model: serial bus master, mode 0, about 8 MHz.
 * Assumes callers start with select idle high. */
`timescale 1ns/1ps
module sqr_host (
	input wire clk_sys_i,
	input wire serial_out_line_i,
	output logic sclk_o,
	output logic select_n_line_o,
	output logic serial_in_line_o
);
	localparam int HALF = 6; // 60 ns half period keeps under 10 MHz
	initial begin
		sclk_o = 1'b0;
		select_n_line_o = 1'b1;
		serial_in_line_o = 1'b0;
	end
	// Byte k of tx at [63-8k -: 8]; rx ends right-aligned
	task automatic xfer(input int n, input logic [63:0] tx,
		output logic [63:0] rx);
		rx = 64'h0;
		@(posedge clk_sys_i);
		#1 select_n_line_o = 1'b0;
		for (int i = 0; i < 8 * n; i++) begin
			serial_in_line_o = tx[63 - i];
			repeat (HALF) @(posedge clk_sys_i);
			#1 sclk_o = 1'b1;
			rx = {rx[62:0], serial_out_line_i};
			repeat (HALF) @(posedge clk_sys_i);
			#1 sclk_o = 1'b0;
		end
		repeat (HALF) @(posedge clk_sys_i);
		#1 select_n_line_o = 1'b1;
		// Released line must not keep its last level
		serial_in_line_o = ~serial_in_line_o;
		repeat (10) @(posedge clk_sys_i);
		#1;
	endtask
endmodule

//--- verif/sqr_port_bench.sv
/* Self-checking bench for sqr_port driven by the host model.
 * Assumes a 100 MHz system clock. */
`timescale 1ns/1ps
module sqr_port_bench;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic sclk, sel_n, serial_in_line, serial_out_line, oe, strobe, first, cend, cts;
	logic [63:0] src = 64'h1122334455667788;
	logic [11:0] prop = 12'h1D5;
	logic [127:0] rbuf = 128'hF0E1D2C3B4A5968778695A4B3C2D1E0F;
	logic done = 1'b0;
	logic [7:0] cbyte;
	logic [63:0] rx;
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;
	int n_strobe = 0;
	int n_end = 0;
	logic [7:0] first_cmd = 8'h00;
	always #5 clk_sys_i = ~clk_sys_i;
	// Command side pulses are short; count them here for t_cmd
	always @(posedge clk_sys_i) begin
		if (strobe) begin
			n_strobe++;
			if (first)
				first_cmd <= cbyte;
		end
		if (cend)
			n_end++;
	end
	sqr_port uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sclk_i(sclk),
		.select_n_line_i(sel_n), .serial_in_line_i(serial_in_line),
		.serial_out_line_o(serial_out_line), .serial_out_line_oe_o(oe),
		.qr_src_i(src), .quick_read_source_property_i(prop),
		.reply_buf_i(rbuf), .proc_done_i(done), .cmd_byte_o(cbyte),
		.cmd_strobe_o(strobe), .cmd_first_o(first), .cmd_end_o(cend),
		.cts_o(cts));
	// Undriven output shows the inverse so a late enable is caught
	sqr_host host (.clk_sys_i(clk_sys_i),
		.serial_out_line_i(oe ? serial_out_line : ~serial_out_line),
		.sclk_o(sclk), .select_n_line_o(sel_n), .serial_in_line_o(serial_in_line));
	function automatic [7:0] qr(input logic [63:0] s, input int r);
		qr = s[8 * prop[3 * r +: 3] +: 8];
	endfunction
	function automatic [7:0] rb(input int n, input int k);
		rb = rx[8 * (n - 1 - k) +: 8];
	endfunction
	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task t_reset;
		check({7'h0, oe}, 8'h00);
		check({7'h0, cts}, 8'h01);
	endtask
	task t_single;
		logic [7:0] c;
		for (int r = 0; r < 4; r++) begin
			c = r == 0 ? 8'h50 : r == 1 ? 8'h51 : r == 2 ? 8'h53 : 8'h57;
			host.xfer(2, {c, 56'h0}, rx);
			check(rx[7:0], qr(src, r));
		end
	endtask
	task t_burst;
		host.xfer(6, {8'h53, 56'h0}, rx);
		for (int k = 1; k < 6; k++)
			check(rb(6, k), qr(src, (k + 1) % 4));
	endtask
	task automatic t_freeze;
		logic [63:0] old;
		old = src;
		fork
			host.xfer(6, {8'h50, 56'h0}, rx);
			begin
				repeat (30) @(posedge clk_sys_i);
				#1 src = ~src;
			end
		join
		for (int k = 1; k < 6; k++)
			check(rb(6, k), qr(old, (k - 1) % 4));
		host.xfer(2, {8'h50, 56'h0}, rx);
		check(rx[7:0], qr(src, 0));
	endtask
	task t_cmd;
		host.xfer(2, {16'h1234, 48'h0}, rx);
		check(cbyte, 8'h34);
		check(n_strobe[7:0], 8'h02);
		check(first_cmd, 8'h12);
		check({7'h0, first}, 8'h00);
		check(n_end[7:0], 8'h01);
		check({7'h0, cts}, 8'h00);
		host.xfer(2, {8'h44, 56'h0}, rx);
		check(rx[7:0], 8'h00);
		@(posedge clk_sys_i);
		#1 done = 1'b1;
		repeat (1700) @(posedge clk_sys_i);
		#1;
		check({7'h0, cts}, 8'h00);
		repeat (200) @(posedge clk_sys_i);
		#1;
		check({7'h0, cts}, 8'h01);
		host.xfer(4, {8'h44, 56'h0}, rx);
		check(rb(4, 1), 8'hFF);
		check(rb(4, 2), rbuf[7:0]);
		check(rb(4, 3), rbuf[15:8]);
		check(n_end[7:0], 8'h01);
	endtask
	task tally_and_finish;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (4) @(posedge clk_sys_i);
		#1 rst_n_i = 1'b1;
		repeat (4) @(posedge clk_sys_i);
		#1;
		t_reset();
		t_single();
		t_burst();
		t_freeze();
		t_cmd();
		tally_and_finish();
	end
endmodule
